/* File: scc_device.sv */
// Purpose: synthesizer end: shift in words, hold calibration registers, run timers
// Assumes: ref_tick is a one-cycle pulse per reference period on clk
// Notes: link wires pass two flip-flops before use
`default_nettype none
module scc_device (
  input wire logic clk,
  input wire logic rst_b,
  scc_link_if.dev link,
  input wire logic ref_tick,
  output logic [7:0] band_division,
  output logic [9:0] band_timeout,
  output logic [4:0] level_cal_wait,
  output logic [4:0] lock_settle,
  output logic [7:0] converter_divisor,
  output logic converter_power,
  output logic conv_busy,
  output logic conv_done,
  output logic pfd_tick,
  output logic [31:0] freq_word,
  output logic freq_apply,
  output logic resync_pulse
);
  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [1:0] prev;
    logic [31:0] shift;
    logic [5:0] nbits;
    logic [31:0] cal;
    logic [31:0] conv;
    logic [15:0] resync_word;
    logic [9:0] ref_div;
    logic cnt_reset;
    logic [9:0] ref_cnt;
    logic phase_detector_rate;
    logic [7:0] pre;
    logic conv_busy;
    logic [4:0] conv_edges;
    logic conv_done;
    logic [31:0] freq_word;
    logic freq_apply;
    logic [15:0] resync_cnt;
    logic resync_run;
    logic resync_pulse;
  } scc_dev_state_type;

  scc_dev_state_type st_r;
  scc_dev_state_type st_nxt;
  logic clk_rise;
  logic load_rise;

  // next state of the whole device
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.sync1 = {link.link_load, link.link_data, link.link_clk};
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev = {st_r.sync2[2], st_r.sync2[0]};
    clk_rise = st_r.sync2[0] && !st_r.prev[0];
    load_rise = st_r.sync2[2] && !st_r.prev[1];
    st_nxt.freq_apply = 1'b0;
    st_nxt.conv_done = 1'b0;
    st_nxt.resync_pulse = 1'b0;
    st_nxt.phase_detector_rate = 1'b0;
    // msb first shift on each link clock rise
    if (clk_rise)
    begin
      st_nxt.shift = {st_r.shift[30:0], st_r.sync2[1]};
      if (st_r.nbits != 6'h3f)
        st_nxt.nbits = st_r.nbits + 6'h01;
    end
    // phase detector tick from reference divided by r
    if (st_r.cnt_reset)
      st_nxt.ref_cnt = 10'h000;
    else if (ref_tick)
    begin
      if (st_r.ref_cnt + 10'h001 >= st_r.ref_div)
      begin
        st_nxt.ref_cnt = 10'h000;
        st_nxt.phase_detector_rate = 1'b1;
      end
      else
        st_nxt.ref_cnt = st_r.ref_cnt + 10'h001;
    end
    // converter clock and 16-clock conversion
    if (!st_r.conv[scc_pkg::CONV_PWR_BIT])
      st_nxt.conv_busy = 1'b0;
    else if (st_r.conv_busy && st_r.phase_detector_rate)
    begin
      if ({2'h0, st_r.pre} + 10'h001 >= {2'h0, st_r.conv[scc_pkg::DIV_MSB:scc_pkg::DIV_LSB]})
      begin
        st_nxt.pre = 8'h00;
        st_nxt.conv_edges = st_r.conv_edges + 5'h01;
        if (st_r.conv_edges == scc_pkg::CONV_WAIT_CLKS - 5'h01)
        begin
          st_nxt.conv_busy = 1'b0;
          st_nxt.conv_done = 1'b1;
        end
      end
      else
        st_nxt.pre = st_r.pre + 8'h01;
    end
    // resync countdown in phase detector ticks
    if (st_r.resync_run && st_r.phase_detector_rate)
    begin
      if (st_r.resync_cnt <= 16'h0001)
      begin
        st_nxt.resync_run = 1'b0;
        st_nxt.resync_pulse = 1'b1;
      end
      else
        st_nxt.resync_cnt = st_r.resync_cnt - 16'h0001;
    end
    // load strobe moves a whole word into its register
    if (load_rise)
    begin
      st_nxt.nbits = 6'h00;
      if (st_r.nbits == 6'(scc_pkg::WORD_W))
      begin
        case (st_r.shift[3:0])
          scc_pkg::SEL_CAL:
            st_nxt.cal = st_r.shift;
          scc_pkg::SEL_CONV:
          begin
            st_nxt.conv = st_r.shift;
            if (st_r.shift[scc_pkg::CONV_ON_WR_BIT] && st_r.shift[scc_pkg::CONV_PWR_BIT])
            begin
              st_nxt.conv_busy = 1'b1;
              st_nxt.pre = 8'h00;
              st_nxt.conv_edges = 5'h00;
            end
          end
          scc_pkg::SEL_RESYNC:
            st_nxt.resync_word = st_r.shift[scc_pkg::RESYNC_MSB:scc_pkg::RESYNC_LSB];
          scc_pkg::SEL_REFDIV:
          begin
            st_nxt.ref_div = st_r.shift[scc_pkg::REFDIV_MSB:scc_pkg::REFDIV_LSB];
            st_nxt.cnt_reset = st_r.shift[scc_pkg::CNT_RESET_BIT];
          end
          scc_pkg::SEL_FREQ:
          begin
            st_nxt.freq_word = st_r.shift;
            st_nxt.freq_apply = 1'b1;
            st_nxt.resync_cnt = st_r.resync_word;
            st_nxt.resync_run = st_r.resync_word != 16'h0000;
          end
          default:
            st_nxt.nbits = 6'h00;
        endcase
      end
    end
  end

  // state register, r divider starts at one
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      st_r <= '0;
      st_r.ref_div <= scc_pkg::REFDIV_RESET;
    end
    else
      st_r <= st_nxt;
  end

  assign band_division = st_r.cal[scc_pkg::BAND_MSB:scc_pkg::BAND_LSB];
  assign band_timeout = st_r.cal[scc_pkg::TMO_MSB:scc_pkg::TMO_LSB];
  assign level_cal_wait = st_r.cal[scc_pkg::ALC_MSB:scc_pkg::ALC_LSB];
  assign lock_settle = st_r.cal[scc_pkg::LOCK_MSB:scc_pkg::LOCK_LSB];
  assign converter_divisor = st_r.conv[scc_pkg::DIV_MSB:scc_pkg::DIV_LSB];
  assign converter_power = st_r.conv[scc_pkg::CONV_PWR_BIT];
  assign conv_busy = st_r.conv_busy;
  assign conv_done = st_r.conv_done;
  assign pfd_tick = st_r.phase_detector_rate;
  assign freq_word = st_r.freq_word;
  assign freq_apply = st_r.freq_apply;
  assign resync_pulse = st_r.resync_pulse;
endmodule
`default_nettype wire

/* File: scc_host.sv */
// Purpose: host end: apb-programmed word sender with content and order checks
// Assumes: one clock; software sets phase detector rate in kHz
// Notes: refused words never reach the link
`default_nettype none
module scc_host #(
  parameter int LINK_HALF = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  scc_link_if.host link
);
  if (LINK_HALF < 2 || LINK_HALF > 65535)
    $error("LINK_HALF out of range");

  typedef enum logic [2:0] {HS_IDLE, HS_LOW, HS_HIGH, HS_LOAD, HS_WAIT} scc_host_phase_type;
  typedef struct packed {
    scc_host_phase_type phase;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [31:0] word;
    logic [31:0] wait_cycles;
    logic [31:0] pfd_khz;
    logic refused;
    logic wait_done;
    logic init_done;
    logic started;
    logic [3:0] last_sel;
    logic [31:0] shift;
    logic [5:0] nbits;
    logic [15:0] half;
    logic [31:0] cnt;
    logic link_clk;
    logic link_data;
    logic link_load;
  } scc_host_state_type;

  scc_host_state_type st_r;
  scc_host_state_type st_nxt;
  logic acc;
  logic busy;
  logic mapped;
  logic half_end;
  logic [3:0] sel;

  // content and order check of a word before it is sent
  function automatic logic word_ok(input logic [31:0] w, input logic [31:0] phase_detector_rate, input logic wdone,
    input logic init_done, input logic started, input logic [3:0] last_sel);
    logic [31:0] band;
    logic [31:0] tmo;
    logic [31:0] div;
    logic ok;
    band = 32'(w[scc_pkg::BAND_MSB:scc_pkg::BAND_LSB]);
    tmo = 32'(w[scc_pkg::TMO_MSB:scc_pkg::TMO_LSB]);
    div = 32'(w[scc_pkg::DIV_MSB:scc_pkg::DIV_LSB]);
    ok = 1'b1;
    if (!init_done && (started ? w[3:0] >= last_sel : w[3:0] != scc_pkg::SEL_RESYNC))
      ok = 1'b0;
    case (w[3:0])
      scc_pkg::SEL_FIXED_A:
        ok = ok && (w == scc_pkg::FIXED_A_WORD);
      scc_pkg::SEL_FIXED_B:
        ok = ok && (w == scc_pkg::FIXED_B_WORD);
      scc_pkg::SEL_CAL:
      begin
        if (phase_detector_rate >= scc_pkg::BAND_LIMIT_KHZ * scc_pkg::BAND_STEPS * band)
          ok = 1'b0;
        if (tmo * 32'(w[scc_pkg::ALC_MSB:scc_pkg::ALC_LSB]) * scc_pkg::KHZ_PER_MHZ <= scc_pkg::ALC_MIN_US * phase_detector_rate)
          ok = 1'b0;
        if (tmo * 32'(w[scc_pkg::LOCK_MSB:scc_pkg::LOCK_LSB]) * scc_pkg::KHZ_PER_MHZ <= scc_pkg::LOCK_MIN_US * phase_detector_rate)
          ok = 1'b0;
      end
      scc_pkg::SEL_CONV:
      begin
        if ((w & scc_pkg::CONV_RSV_MASK) != scc_pkg::CONV_RSV_VAL)
          ok = 1'b0;
        if (div == 32'h0)
          ok = 1'b0;
        if (div != scc_pkg::DIV_MAX &&
            (scc_pkg::DIV_SCALE * div + scc_pkg::DIV_OFFSET) * scc_pkg::DIV_STEP_KHZ < phase_detector_rate)
          ok = 1'b0;
        if (div > 32'h1 && (scc_pkg::DIV_SCALE * div - scc_pkg::DIV_OFFSET) * scc_pkg::DIV_STEP_KHZ >= phase_detector_rate)
          ok = 1'b0;
      end
      scc_pkg::SEL_RESYNC:
      begin
        if ((w & scc_pkg::RESYNC_RSV_MASK) != scc_pkg::RESYNC_RSV_VAL)
          ok = 1'b0;
        if (w[scc_pkg::RESYNC_MSB:scc_pkg::RESYNC_LSB] == 16'h0000)
          ok = 1'b0;
      end
      scc_pkg::SEL_FREQ:
        if (w[scc_pkg::AUTOCAL_BIT] && !wdone)
          ok = 1'b0;
      default:
        ok = ok && 1'b1;
    endcase
    return ok;
  endfunction

  // apb slave, link shifter and wait timer
  always_comb
  begin
    st_nxt = st_r;
    acc = psel && penable && st_r.pready;
    busy = st_r.phase != HS_IDLE;
    sel = st_r.word[3:0];
    half_end = st_r.half == 16'(LINK_HALF - 1);
    mapped = paddr == scc_pkg::ADDR_WORD || paddr == scc_pkg::ADDR_CMD || paddr == scc_pkg::ADDR_WAIT ||
             paddr == scc_pkg::ADDR_PFD || paddr == scc_pkg::ADDR_STATUS;
    // answer one cycle into the access phase
    st_nxt.pready = psel && penable && !st_r.pready;
    if (psel && penable && !st_r.pready)
    begin
      st_nxt.pslverr = !mapped || (pwrite && paddr == scc_pkg::ADDR_CMD && busy);
      case (paddr)
        scc_pkg::ADDR_WORD:
          st_nxt.prdata = st_r.word;
        scc_pkg::ADDR_WAIT:
          st_nxt.prdata = st_r.wait_cycles;
        scc_pkg::ADDR_PFD:
          st_nxt.prdata = st_r.pfd_khz;
        scc_pkg::ADDR_STATUS:
          st_nxt.prdata = {27'h0, st_r.pfd_khz > scc_pkg::HALF_RATE_KHZ, st_r.init_done,
                           st_r.wait_done, st_r.refused, busy};
        default:
          st_nxt.prdata = 32'h0;
      endcase
    end
    // register writes at the completing edge
    if (acc && pwrite && !st_r.pslverr)
    begin
      case (paddr)
        scc_pkg::ADDR_WORD:
          st_nxt.word = pwdata;
        scc_pkg::ADDR_WAIT:
          st_nxt.wait_cycles = pwdata;
        scc_pkg::ADDR_PFD:
          st_nxt.pfd_khz = pwdata;
        scc_pkg::ADDR_STATUS:
          if (pwdata[scc_pkg::ST_REFUSED_BIT])
            st_nxt.refused = 1'b0;
        default:
          st_nxt.refused = st_nxt.refused;
      endcase
    end
    // link and timer sequencing
    st_nxt.half = half_end ? 16'h0000 : st_r.half + 16'h0001;
    case (st_r.phase)
      HS_IDLE:
      begin
        st_nxt.half = 16'h0000;
        if (acc && pwrite && !st_r.pslverr && paddr == scc_pkg::ADDR_CMD)
        begin
          if (pwdata[scc_pkg::CMD_SEND_BIT])
          begin
            if (word_ok(st_r.word, st_r.pfd_khz, st_r.wait_done, st_r.init_done, st_r.started, st_r.last_sel))
            begin
              st_nxt.phase = HS_LOW;
              st_nxt.shift = st_r.word;
              st_nxt.nbits = 6'h00;
              st_nxt.link_data = st_r.word[scc_pkg::WORD_W - 1];
              st_nxt.started = 1'b1;
              st_nxt.last_sel = sel;
              if (sel == scc_pkg::SEL_FREQ)
                st_nxt.init_done = 1'b1;
              if (sel == scc_pkg::SEL_REFDIV || sel == 4'h1 ||
                  (sel == scc_pkg::SEL_FREQ && st_r.word[scc_pkg::AUTOCAL_BIT]))
                st_nxt.wait_done = 1'b0;
            end
            else
              st_nxt.refused = 1'b1;
          end
          else if (pwdata[scc_pkg::CMD_WAIT_BIT])
          begin
            st_nxt.phase = HS_WAIT;
            st_nxt.cnt = st_r.wait_cycles;
          end
        end
      end
      HS_LOW:
        if (half_end)
        begin
          st_nxt.link_clk = 1'b1;
          st_nxt.phase = HS_HIGH;
        end
      HS_HIGH:
        if (half_end)
        begin
          st_nxt.link_clk = 1'b0;
          if (st_r.nbits == 6'(scc_pkg::WORD_W - 1))
          begin
            st_nxt.phase = HS_LOAD;
            st_nxt.link_load = 1'b1;
            st_nxt.link_data = 1'b0;
          end
          else
          begin
            st_nxt.phase = HS_LOW;
            st_nxt.nbits = st_r.nbits + 6'h01;
            st_nxt.shift = {st_r.shift[30:0], 1'b0};
            st_nxt.link_data = st_r.shift[30];
          end
        end
      HS_LOAD:
        if (half_end)
        begin
          st_nxt.link_load = 1'b0;
          st_nxt.phase = HS_IDLE;
        end
      HS_WAIT:
        if (st_r.cnt == 32'h0)
        begin
          st_nxt.wait_done = 1'b1;
          st_nxt.phase = HS_IDLE;
        end
        else
          st_nxt.cnt = st_r.cnt - 32'h1;
      default:
        st_nxt.phase = HS_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign link.link_clk = st_r.link_clk;
  assign link.link_data = st_r.link_data;
  assign link.link_load = st_r.link_load;
endmodule
`default_nettype wire

/* File: scc_link_if.sv */
// Purpose: three-wire serial link between host and synthesizer
// Assumes: host drives every wire
// Notes: no clocking block, both ends sample on their own clock
`default_nettype none
interface scc_link_if;
  logic link_clk;
  logic link_data;
  logic link_load;
  modport host (output link_clk, output link_data, output link_load);
  modport dev (input link_clk, input link_data, input link_load);
endinterface
`default_nettype wire

/* File: scc_pkg.sv */
// Purpose: shared constants for the synthesizer calibration link, both ends
// Assumes: 32-bit words with a 4-bit register select in the low bits
// Notes: rates are in kHz, times in us
`default_nettype none
package scc_pkg;
  localparam int WORD_W = 32;
  // register select codes
  localparam logic [3:0] SEL_FREQ = 4'h0;
  localparam logic [3:0] SEL_REFDIV = 4'h4;
  localparam logic [3:0] SEL_FIXED_A = 4'h8;
  localparam logic [3:0] SEL_CAL = 4'h9;
  localparam logic [3:0] SEL_CONV = 4'ha;
  localparam logic [3:0] SEL_FIXED_B = 4'hb;
  localparam logic [3:0] SEL_RESYNC = 4'hc;
  localparam logic [31:0] FIXED_A_WORD = 32'h102d0428;
  localparam logic [31:0] FIXED_B_WORD = 32'h0061300b;
  // calibration timing fields
  localparam int BAND_MSB = 31;
  localparam int BAND_LSB = 24;
  localparam int TMO_MSB = 23;
  localparam int TMO_LSB = 14;
  localparam int ALC_MSB = 13;
  localparam int ALC_LSB = 9;
  localparam int LOCK_MSB = 8;
  localparam int LOCK_LSB = 4;
  // temperature converter control fields
  localparam logic [31:0] CONV_RSV_MASK = 32'hffffc000;
  localparam logic [31:0] CONV_RSV_VAL = 32'h00c00000;
  localparam int DIV_MSB = 13;
  localparam int DIV_LSB = 6;
  localparam int CONV_ON_WR_BIT = 5;
  localparam int CONV_PWR_BIT = 4;
  localparam logic [4:0] CONV_WAIT_CLKS = 5'h10;
  // resync timer fields
  localparam int RESYNC_MSB = 31;
  localparam int RESYNC_LSB = 16;
  localparam logic [31:0] RESYNC_RSV_MASK = 32'h0000fff0;
  localparam logic [31:0] RESYNC_RSV_VAL = 32'h00000410;
  // frequency and reference divider words
  localparam int AUTOCAL_BIT = 21;
  localparam int CNT_RESET_BIT = 4;
  localparam int REFDIV_MSB = 23;
  localparam int REFDIV_LSB = 14;
  localparam logic [9:0] REFDIV_RESET = 10'h001;
  // host side limits
  localparam logic [31:0] BAND_LIMIT_KHZ = 32'h00000096;
  localparam logic [31:0] BAND_STEPS = 32'h00000010;
  localparam logic [31:0] ALC_MIN_US = 32'h00000032;
  localparam logic [31:0] LOCK_MIN_US = 32'h00000014;
  localparam logic [31:0] KHZ_PER_MHZ = 32'h000003e8;
  localparam logic [31:0] DIV_STEP_KHZ = 32'h00000064;
  localparam logic [31:0] DIV_OFFSET = 32'h00000002;
  localparam logic [31:0] DIV_SCALE = 32'h00000004;
  localparam logic [31:0] DIV_MAX = 32'h000000ff;
  localparam logic [31:0] HALF_RATE_KHZ = 32'h000124f8;
  // host apb map
  localparam logic [7:0] ADDR_WORD = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_WAIT = 8'h08;
  localparam logic [7:0] ADDR_PFD = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam int CMD_SEND_BIT = 0;
  localparam int CMD_WAIT_BIT = 1;
  localparam int ST_REFUSED_BIT = 1;
endpackage
`default_nettype wire

/* File: scc_props.sv */
// Purpose: link framing and device routing checks
// Assumes: both ends share clk and rst_b
// Notes: helper logic rebuilds the last loaded word
`default_nettype none
module scc_props #(
  parameter int LINK_HALF = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire logic link_data,
  input wire logic link_load,
  input wire logic freq_apply,
  input wire logic [31:0] freq_word,
  input wire logic [7:0] band_division,
  input wire logic [9:0] band_timeout,
  input wire logic [4:0] level_cal_wait,
  input wire logic [4:0] lock_settle,
  input wire logic [7:0] converter_divisor,
  input wire logic converter_power,
  input wire logic conv_busy,
  input wire logic conv_done
);
  logic [31:0] sh_r;
  logic [31:0] word_r;
  logic [5:0] bits_r;
  logic [3:0] hold_r;
  logic [3:0] since_r;
  logic clk_d_r;
  logic load_d_r;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // shadow shifter, bit count, load width and age
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      sh_r <= '0;
      word_r <= '0;
      bits_r <= '0;
      hold_r <= '0;
      since_r <= 4'hf;
      clk_d_r <= 1'b0;
      load_d_r <= 1'b0;
    end
    else
    begin
      clk_d_r <= link_clk;
      load_d_r <= link_load;
      hold_r <= link_load ? hold_r + 4'h1 : 4'h0;
      if (link_clk && !clk_d_r)
      begin
        sh_r <= {sh_r[30:0], link_data};
        bits_r <= bits_r + 6'h01;
      end
      if (link_load && !load_d_r)
      begin
        word_r <= sh_r;
        bits_r <= '0;
        since_r <= '0;
      end
      else if (since_r != 4'hf)
        since_r <= since_r + 4'h1;
    end
  end
  AST_LOAD_CLK_LOW: assert property (link_load |-> !link_clk)
    else $error("link clock high during load");
  AST_DATA_STEADY: assert property (link_clk && $past(link_clk) |-> $stable(link_data))
    else $error("link data moved while clock high");
  AST_BIT_COUNT: assert property ($rose(link_load) |-> bits_r == 6'd32)
    else $error("load without 32 bits");
  AST_LOAD_WIDTH: assert property ($fell(link_load) |-> hold_r == LINK_HALF)
    else $error("load strobe width wrong");
  AST_APPLY_ON_ZERO: assert property (freq_apply |-> since_r <= 4'd6 && word_r[3:0] == 4'h0)
    else $error("frequency applied without register zero load");
  AST_APPLY_WORD: assert property (freq_apply |=> freq_word == word_r)
    else $error("frequency word differs from loaded word");
  AST_CAL_ROUTE: assert property (($changed(band_timeout) || $changed(band_division)) |->
    word_r[3:0] == 4'h9 && {band_division, band_timeout} == word_r[31:14])
    else $error("calibration timing fields wrong");
  AST_CAL_WAITS: assert property (($changed(level_cal_wait) || $changed(lock_settle)) |->
    word_r[3:0] == 4'h9 && {level_cal_wait, lock_settle} == word_r[13:4])
    else $error("calibration wait fields wrong");
  AST_DIV_ROUTE: assert property ($changed(converter_divisor) |->
    word_r[3:0] == 4'ha && converter_divisor == word_r[13:6])
    else $error("converter divisor wrong");
  AST_PWR_ROUTE: assert property ($changed(converter_power) |->
    word_r[3:0] == 4'ha && converter_power == word_r[4])
    else $error("converter power wrong");
  AST_DONE_BUSY: assert property ($rose(conv_done) |-> $past(conv_busy))
    else $error("conversion done without busy");
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Purpose: both ends joined, host driven over apb
// Assumes: phase detector rate 60000 kHz, link half period 2
// Notes: random reference ticks and frequency payloads from an lfsr
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; $display("FAIL %0t got %h want %h", $time, (a), (b)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] W12 = {16'h0005, 12'h041, scc_pkg::SEL_RESYNC};
  localparam logic [31:0] W10 = {8'h00, 2'b11, 8'h00, 8'h96, 2'b11, scc_pkg::SEL_CONV};
  localparam logic [31:0] W9 = {8'h1a, 10'h067, 5'h1e, 5'h0c, scc_pkg::SEL_CAL};
  localparam logic [31:0] W4 = {8'h00, 10'h001, 10'h000, scc_pkg::SEL_REFDIV};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic ref_tick = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd_q, freq_word, fw;
  logic pready, pslverr, rd_err, freq_apply, conv_busy, conv_done, pfd_tick, resync_pulse, converter_power;
  logic pend = 1'b0;
  logic [7:0] band_division, converter_divisor;
  logic [9:0] band_timeout;
  logic [4:0] level_cal_wait, lock_settle;
  logic [15:0] lfsr_r = 16'hd939;
  int failures = 0;
  int checked = 0;
  int applies = 0;
  int convs = 0;
  int resyncs = 0;
  int pfds = 0;
  int pfd_snap = 0;
  logic [31:0] exp_w;
  logic [31:0] exp_q [$];
  logic [31:0] iw [12] = '{W12, scc_pkg::FIXED_B_WORD, W10, W9, scc_pkg::FIXED_A_WORD, 32'h7, 32'h6, 32'h5,
    W4, 32'h3, 32'h2, 32'h1};
  logic [31:0] bw [8] = '{scc_pkg::FIXED_A_WORD ^ 32'h100, scc_pkg::FIXED_B_WORD ^ 32'h1000, W10 ^ 32'h00400000,
    W10 ^ 32'h40, W12 ^ 32'h400, {8'h19, W9[23:0]}, {W9[31:24], 10'h064, W9[13:0]}, 32'h00200000};
  scc_link_if scc_link_if_i ();
  scc_host #(.LINK_HALF(2)) scc_host_i (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(scc_link_if_i));
  scc_device scc_device_i (.clk(clk), .rst_b(rst_b), .link(scc_link_if_i), .ref_tick(ref_tick),
    .band_division(band_division), .band_timeout(band_timeout), .level_cal_wait(level_cal_wait),
    .lock_settle(lock_settle), .converter_divisor(converter_divisor), .converter_power(converter_power),
    .conv_busy(conv_busy), .conv_done(conv_done), .pfd_tick(pfd_tick), .freq_word(freq_word),
    .freq_apply(freq_apply), .resync_pulse(resync_pulse));
  scc_props #(.LINK_HALF(2)) scc_props_i (.clk(clk), .rst_b(rst_b), .link_clk(scc_link_if_i.link_clk),
    .link_data(scc_link_if_i.link_data), .link_load(scc_link_if_i.link_load), .freq_apply(freq_apply),
    .freq_word(freq_word), .band_division(band_division), .band_timeout(band_timeout),
    .level_cal_wait(level_cal_wait), .lock_settle(lock_settle), .converter_divisor(converter_divisor),
    .converter_power(converter_power), .conv_busy(conv_busy), .conv_done(conv_done));
  // clock
  always #2 clk = ~clk;
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [31:0] fword(input logic ac);
    return {10'h000, ac, lfsr_r, 1'b0, scc_pkg::SEL_FREQ};
  endfunction
  // random reference ticks
  always @(posedge clk)
  begin
    lfsr_r <= lfsr_next(lfsr_r);
    ref_tick <= lfsr_r[0];
  end
  // output watcher: frequency words against notes, pulse counts
  always @(posedge clk)
  begin
    if (pend)
    begin
      if (exp_q.size() == 0)
        `CHK(1'b1, 1'b0)
      else
      begin
        exp_w = exp_q.pop_front();
        `CHK(freq_word, exp_w)
      end
    end
    pend = (rst_b === 1'b1) && (freq_apply === 1'b1);
    if (pend)
      applies++;
    if (conv_done === 1'b1)
      convs++;
    if (resync_pulse === 1'b1)
      resyncs++;
    if (pfd_tick === 1'b1)
      pfds++;
  end
  task automatic summarize();
    if (failures == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic bail();
    failures++;
    summarize();
  endtask
  // one apb transfer, waits for pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd_q = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
      bail();
  endtask
  // poll busy until clear
  task automatic idle();
    int n;
    n = 0;
    do
    begin
      apb(1'b0, scc_pkg::ADDR_STATUS, 32'h0);
      n++;
    end
    while (rd_q[0] !== 1'b0 && n < 200);
    if (n >= 200)
      bail();
  endtask
  task automatic send(input logic [31:0] w);
    apb(1'b1, scc_pkg::ADDR_WORD, w);
    apb(1'b1, scc_pkg::ADDR_CMD, 32'h1);
    idle();
  endtask
  task automatic settle();
    apb(1'b1, scc_pkg::ADDR_WAIT, 32'h64);
    apb(1'b1, scc_pkg::ADDR_CMD, 32'h2);
    idle();
    apb(1'b0, scc_pkg::ADDR_STATUS, 32'h0);
    `CHK(rd_q[2], 1'b1)
  endtask
  // main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b1, scc_pkg::ADDR_PFD, 32'h0000ea60);
    foreach (iw[i])
      send(iw[i]);
    settle();
    fw = fword(1'b1);
    exp_q.push_back(fw);
    send(fw);
    apb(1'b0, scc_pkg::ADDR_STATUS, 32'h0);
    `CHK(rd_q[4:1], 4'b0100)
    `CHK({band_division, band_timeout, level_cal_wait, lock_settle}, W9[31:4])
    `CHK({converter_divisor, converter_power}, {W10[13:6], W10[4]})
    for (int n = 0; n < 20000 && convs == 0; n++)
      @(posedge clk);
    `CHK(convs > 0, 1'b1)
    `CHK(resyncs > 0, 1'b1)
    // words that break content rules never reach the link
    foreach (bw[i])
    begin
      send(bw[i]);
      apb(1'b0, scc_pkg::ADDR_STATUS, 32'h0);
      `CHK(rd_q[1], 1'b1)
      apb(1'b1, scc_pkg::ADDR_STATUS, 32'h2);
    end
    apb(1'b0, 8'h20, 32'h0);
    `CHK(rd_err, 1'b1)
    // fast rate flag above the half-rate threshold
    apb(1'b1, scc_pkg::ADDR_PFD, 32'h00013880);
    apb(1'b0, scc_pkg::ADDR_STATUS, 32'h0);
    `CHK(rd_q[4], 1'b1)
    apb(1'b1, scc_pkg::ADDR_PFD, 32'h0000ea60);
    // update with counter reset, wait, autocal
    send(W10);
    send(W4 | 32'h10);
    repeat (2) @(posedge clk);
    pfd_snap = pfds;
    `CHK(conv_busy, 1'b1)
    // second command while the link is busy is refused
    apb(1'b1, scc_pkg::ADDR_WORD, 32'h2);
    apb(1'b1, scc_pkg::ADDR_CMD, 32'h1);
    apb(1'b1, scc_pkg::ADDR_CMD, 32'h1);
    `CHK(rd_err, 1'b1)
    idle();
    send(32'h1);
    fw = fword(1'b0);
    exp_q.push_back(fw);
    send(fw);
    `CHK(pfds, pfd_snap)
    send(W4);
    settle();
    fw = fword(1'b1);
    exp_q.push_back(fw);
    send(fw);
    repeat (10) @(posedge clk);
    `CHK(applies, 3)
    `CHK(exp_q.size(), 0)
    summarize();
  end
endmodule
`default_nettype wire
